// ---- rtl/anr_pkg.sv ----
// Shared constants for the auto-negotiation register set
package anr_pkg;

  // Management frame addressing
  localparam logic [4:0]  ANR_PHY_ADDR    = 5'h18;
  localparam logic [4:0]  ANR_REG_CTRL    = 5'h00;
  localparam logic [4:0]  ANR_REG_ADV     = 5'h04;
  localparam logic [4:0]  ANR_REG_LP      = 5'h05;
  localparam logic [4:0]  ANR_REG_EXP     = 5'h06;
  localparam logic [1:0]  ANR_OP_RD       = 2'h2;
  localparam logic [1:0]  ANR_OP_WR       = 2'h1;

  // Frame bit counts, held in a six-bit counter
  localparam logic [5:0]  ANR_PRE_LEN     = 6'h20;
  localparam logic [5:0]  ANR_HDR_LAST    = 6'h0B;
  localparam logic [5:0]  ANR_TA_LAST     = 6'h01;
  localparam logic [5:0]  ANR_DATA_LAST   = 6'h0F;
  localparam logic [5:0]  ANR_CNT_ONE     = 6'h01;

  // Header field positions inside the twelve shifted bits
  localparam int          ANR_HDR_OP_LSB  = 10;
  localparam int          ANR_HDR_PHY_LSB = 5;

  // Advertisement word layout
  localparam logic [15:0] ANR_SELECTOR    = 16'h0001;
  localparam logic [15:0] ANR_ADV_WMASK   = 16'h81E0;
  localparam logic [15:0] ANR_ADV_RESET   = 16'h01E0;
  localparam int          ANR_ADV_10H     = 5;
  localparam int          ANR_ADV_10F     = 6;
  localparam int          ANR_ADV_TXH     = 7;
  localparam int          ANR_ADV_TXF     = 8;
  localparam int          ANR_ADV_T4      = 9;
  localparam int          ANR_ADV_PAUSE   = 10;
  localparam int          ANR_ADV_RF      = 13;
  localparam int          ANR_ADV_ACK     = 14;
  localparam int          ANR_ADV_NP      = 15;

  // Partner word and expansion word layout
  localparam int          ANR_LP_NP       = 15;
  localparam logic [10:0] ANR_EXP_UNUSED  = 11'h000;

  // Control register layout
  localparam logic [15:0] ANR_CTRL_WMASK  = 16'hFF80;
  localparam logic [15:0] ANR_CTRL_RESET  = 16'h0000;
  localparam int          ANR_CTRL_RESTART = 9;
  localparam int          ANR_CTRL_SWRST  = 15;
  localparam logic [6:0]  ANR_CTRL_LOW0   = 7'h00;

  localparam logic [15:0] ANR_WORD_ZERO   = 16'h0000;

endpackage

// ---- rtl/anr_flag_if.sv ----
// Carrier between the register bank and one latched status flag
`timescale 1ns/1ps
interface anr_flag_if;
  logic set;
  logic clr;
  logic q;
  modport flag (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface

// ---- rtl/anr_flag.sv ----
// Latch-high status flag cleared by a register read
`timescale 1ns/1ps
module anr_flag
(
  input  wire logic i_clk,   // System clock
  input  wire logic i_nrst,  // Asynchronous reset, active low
  anr_flag_if.flag  f        // Set, clear and flag value
);

  logic next_q;

  // Set beats clear so an event during the clearing read is kept
  always_comb
  begin
    next_q = f.set | (f.q & ~f.clr);
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      f.q <= 1'b0;
    else
      f.q <= next_q;
  end

endmodule

// ---- rtl/anr_ability_regs.sv ----
// Auto-negotiation register set behind a management serial port
`timescale 1ns/1ps

// Overview of operation
// - Advertisement bits four to zero are fixed at the selector value.
// - Advertisement bit five offers ten megabit half duplex.
// - Advertisement bit six offers ten megabit full duplex.
// - Advertisement bit seven offers hundred megabit half duplex.
// - Advertisement bit eight offers hundred megabit full duplex.
// - Advertisement bit nine always reads zero.
// - Advertisement bit ten, pause, always reads one.
// - Advertisement bit thirteen is read-only and sends remote fault.
// - Advertisement bit fourteen carries the transmitted acknowledge.
// - Advertisement bit fifteen enables next page exchange.
// - Writes to the expansion register are ignored.
// - Expansion bit zero shows partner can negotiate.
// - Expansion bit one latches high on each received page.
// - Expansion bit two shows local next page support.
// - Expansion bit three shows partner next page support.
// - Partner word bits four to zero hold the received selector.
// - Partner bits twelve to five hold partner technology abilities.
// - Partner bit thirteen shows partner fault.
// - Partner bit fifteen shows partner next page request.
// - Registers answer management frames at address 11000b only.
// - Control at 00, advertisement 04, partner 05, expansion 06.
module anr_ability_regs
#(
  parameter logic NP_ABLE = 1'b1  // Local next page support
)
(
  input  wire logic        i_clk,           // System clock, 50 MHz
  input  wire logic        i_nrst,          // Async reset, active low
  input  wire logic        i_mdc,           // Management clock
  input  wire logic        i_mdio,          // Management data in
  output logic             o_mdio,          // Management data out
  output logic             o_mdio_oe,       // High while driving data
  input  wire logic        i_remote_fault,  // Local fault to send
  input  wire logic        i_ack_tx,        // Acknowledge being sent
  input  wire logic        i_lp_an_able,    // Partner can negotiate
  input  wire logic        i_page_rx,       // Pulse: new partner page
  input  wire logic [15:0] i_lp_word,       // Received code word
  input  wire logic        i_par_det_fault, // Pulse: parallel fault
  output logic      [15:0] o_adv_word,      // Code word to transmit
  output logic      [15:0] o_ctrl_word      // Control register image
);
  import anr_pkg::*;

  typedef enum logic [2:0] {
    ANR_PRE, ANR_START, ANR_HDR, ANR_TA, ANR_DATA
  } anr_state_t;

  default clocking anr_cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  anr_state_t  state, next_state;
  logic [5:0]  cnt, next_cnt;
  logic [15:0] shreg, next_shreg;
  logic [15:0] rd_shift, next_rd_shift;
  logic [1:0]  op, next_op;
  logic [4:0]  phy, next_phy;
  logic [4:0]  regad, next_regad;
  logic        mdc_q;
  logic        rd_go, next_rd_go;
  logic        wr_go, next_wr_go;
  logic        next_mdio, next_mdio_oe;
  logic        rise;
  logic        hit;
  logic        rd_hit, wr_hit;

  logic [15:0] adv, next_adv, next_adv_word;
  logic [15:0] lp, next_lp;
  logic [15:0] next_ctrl;
  logic [15:0] exp_word;
  logic [15:0] rd_mux;
  logic [15:0] hdr_next;

  anr_flag_if page_if ();
  anr_flag_if pdf_if ();

  anr_flag u_page
  (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .f      (page_if)
  );

  anr_flag u_pdf
  (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .f      (pdf_if)
  );

  // Pins are synchronous, so a registered copy suffices for edges
  assign rise     = i_mdc & ~mdc_q;
  assign hit      = (phy == ANR_PHY_ADDR);
  assign rd_hit   = hit && (op == ANR_OP_RD);
  assign wr_hit   = hit && (op == ANR_OP_WR);
  assign hdr_next = {shreg[14:0], i_mdio};

  assign page_if.set = i_page_rx;
  assign page_if.clr = rd_go && (regad == ANR_REG_EXP);
  assign pdf_if.set  = i_par_det_fault;
  assign pdf_if.clr  = rd_go && (regad == ANR_REG_EXP);

  // Management frame sequencer
  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_shreg    = shreg;
    next_rd_shift = rd_shift;
    next_op       = op;
    next_phy      = phy;
    next_regad    = regad;
    next_rd_go    = 1'b0;
    next_wr_go    = 1'b0;
    next_mdio     = o_mdio;
    next_mdio_oe  = o_mdio_oe;
    if (rd_go)
      next_rd_shift = rd_mux;
    if (rise)
    begin
      unique case (state)
        ANR_PRE:
        begin
          if (i_mdio && (cnt != ANR_PRE_LEN))
            next_cnt = cnt + ANR_CNT_ONE;
          if (!i_mdio)
            next_cnt = '0;
          if (!i_mdio && (cnt == ANR_PRE_LEN))
            next_state = ANR_START;
        end
        ANR_START:
        begin
          next_state = i_mdio ? ANR_HDR : ANR_PRE;
          next_cnt   = '0;
        end
        ANR_HDR:
        begin
          next_shreg = hdr_next;
          next_cnt   = cnt + ANR_CNT_ONE;
          if (cnt == ANR_HDR_LAST)
          begin
            next_op    = hdr_next[ANR_HDR_OP_LSB +: 2];
            next_phy   = hdr_next[ANR_HDR_PHY_LSB +: 5];
            next_regad = hdr_next[4:0];
            next_cnt   = '0;
            // Reserved opcodes abandon the frame and wait for preamble
            if ((next_op == ANR_OP_RD) || (next_op == ANR_OP_WR))
              next_state = ANR_TA;
            else
              next_state = ANR_PRE;
            next_rd_go = (next_op == ANR_OP_RD) &&
                         (next_phy == ANR_PHY_ADDR);
          end
        end
        ANR_TA:
        begin
          next_cnt = cnt + ANR_CNT_ONE;
          if (rd_hit)
          begin
            next_mdio_oe = 1'b1;
            if (cnt == ANR_TA_LAST)
            begin
              next_mdio     = rd_shift[15];
              next_rd_shift = {rd_shift[14:0], 1'b0};
            end
            else
              next_mdio = 1'b0;
          end
          if (cnt == ANR_TA_LAST)
          begin
            next_state = ANR_DATA;
            next_cnt   = '0;
          end
        end
        ANR_DATA:
        begin
          next_shreg = hdr_next;
          next_cnt   = cnt + ANR_CNT_ONE;
          if (rd_hit)
          begin
            next_mdio     = rd_shift[15];
            next_rd_shift = {rd_shift[14:0], 1'b0};
          end
          if (cnt == ANR_DATA_LAST)
          begin
            next_state   = ANR_PRE;
            next_cnt     = '0;
            next_mdio_oe = 1'b0;
            next_mdio    = 1'b0;
            next_wr_go   = wr_hit;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state     <= ANR_PRE;
      cnt       <= '0;
      shreg     <= ANR_WORD_ZERO;
      rd_shift  <= ANR_WORD_ZERO;
      op        <= 2'h0;
      phy       <= 5'h00;
      regad     <= 5'h00;
      mdc_q     <= 1'b0;
      rd_go     <= 1'b0;
      wr_go     <= 1'b0;
      o_mdio    <= 1'b0;
      o_mdio_oe <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      shreg     <= next_shreg;
      rd_shift  <= next_rd_shift;
      op        <= next_op;
      phy       <= next_phy;
      regad     <= next_regad;
      mdc_q     <= i_mdc;
      rd_go     <= next_rd_go;
      wr_go     <= next_wr_go;
      o_mdio    <= next_mdio;
      o_mdio_oe <= next_mdio_oe;
    end
  end

  // Expansion image; snapshot for a read is taken before the clear lands
  assign exp_word = {ANR_EXP_UNUSED,
                     pdf_if.q,
                     lp[ANR_LP_NP],
                     NP_ABLE,
                     page_if.q,
                     i_lp_an_able};

  // Unlisted addresses read as zero
  always_comb
  begin
    unique case (regad)
      ANR_REG_CTRL: rd_mux = o_ctrl_word;
      ANR_REG_ADV:  rd_mux = o_adv_word;
      ANR_REG_LP:   rd_mux = lp;
      ANR_REG_EXP:  rd_mux = exp_word;
      default:      rd_mux = ANR_WORD_ZERO;
    endcase
  end

  // Register bank
  always_comb
  begin
    next_adv  = adv;
    next_lp   = lp;
    next_ctrl = o_ctrl_word;
    // Restart and soft reset show for one cycle, then clear themselves
    next_ctrl[ANR_CTRL_RESTART] = 1'b0;
    next_ctrl[ANR_CTRL_SWRST]   = 1'b0;
    if (wr_go)
    begin
      // Partner and expansion words take no writes
      if (regad == ANR_REG_ADV)
        next_adv = shreg & ANR_ADV_WMASK;
      else if (regad == ANR_REG_CTRL)
        next_ctrl = shreg & ANR_CTRL_WMASK;
    end
    if (i_page_rx)
      next_lp = i_lp_word;
    next_adv_word = (next_adv & ANR_ADV_WMASK) | ANR_SELECTOR;
    next_adv_word[ANR_ADV_T4]    = 1'b0;
    next_adv_word[ANR_ADV_PAUSE] = 1'b1;
    next_adv_word[ANR_ADV_RF]    = i_remote_fault;
    next_adv_word[ANR_ADV_ACK]   = i_ack_tx;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      adv         <= ANR_ADV_RESET;
      lp          <= ANR_WORD_ZERO;
      o_ctrl_word <= ANR_CTRL_RESET;
      o_adv_word  <= ANR_ADV_RESET | ANR_SELECTOR | 16'h0400;
    end
    else
    begin
      adv         <= next_adv;
      lp          <= next_lp;
      o_ctrl_word <= next_ctrl;
      o_adv_word  <= next_adv_word;
    end
  end

  a_selector_fixed: assert property (
    o_adv_word[4:0] == ANR_SELECTOR[4:0])
    else $error("selector field not fixed");
  a_ten_half_bit: assert property (
    wr_go && regad == ANR_REG_ADV |=> o_adv_word[5] == $past(shreg[5]))
    else $error("10 half ability not taken");
  a_ten_full_bit: assert property (
    wr_go && regad == ANR_REG_ADV |=> o_adv_word[6] == $past(shreg[6]))
    else $error("10 full ability not taken");
  a_tx_half_bit: assert property (
    wr_go && regad == ANR_REG_ADV |=> o_adv_word[7] == $past(shreg[7]))
    else $error("100 half ability not taken");
  a_tx_full_bit: assert property (
    wr_go && regad == ANR_REG_ADV |=> o_adv_word[8] == $past(shreg[8]))
    else $error("100 full ability not taken");
  a_fixed_bits: assert property (
    !o_adv_word[9] && o_adv_word[10] && o_adv_word[12:11] == 2'h0)
    else $error("fixed ability bits wrong");
  a_fault_follow: assert property (
    ##1 o_adv_word[13] == $past(i_remote_fault))
    else $error("remote fault bit not tracking");
  a_ack_follow: assert property (
    ##1 o_adv_word[14] == $past(i_ack_tx))
    else $error("acknowledge bit not tracking");
  a_page_latch: assert property (
    i_page_rx |=> page_if.q && lp == $past(i_lp_word))
    else $error("page not latched");
  a_pdf_clear: assert property (
    pdf_if.clr && !i_par_det_fault |=> !pdf_if.q)
    else $error("fault flag not cleared by read");
  a_exp_upper_zero: assert property (
    exp_word[15:5] == ANR_EXP_UNUSED && o_ctrl_word[6:0] == ANR_CTRL_LOW0)
    else $error("unused bits not zero");
  a_turn_drive: assert property (
    rise && state == ANR_TA && cnt == 6'h00 && rd_hit
      |=> o_mdio_oe && !o_mdio)
    else $error("turnaround zero not driven");

endmodule

// ---- sim/anr_link_partner.sv ----
// Far-end station model that delivers received link code words
`timescale 1ns/1ps
module anr_link_partner
(
  input  wire logic        i_clk,     // System clock
  output logic             o_page_rx, // Pulse: page delivered
  output logic      [15:0] o_lp_word  // Delivered code word
);
  initial
  begin
    o_page_rx = 1'b0;
    o_lp_word = 16'hA5A5;
  end

  // The word is valid only with the pulse; it is inverted afterwards so a
  // design that samples late sees garbage rather than a held value
  task automatic send_page(input logic [15:0] w);
    @(negedge i_clk);
    o_page_rx = 1'b1;
    o_lp_word = w;
    @(negedge i_clk);
    o_page_rx = 1'b0;
    o_lp_word = ~w;
  endtask
endmodule

// ---- sim/anr_ability_regs_tb.sv ----
// Self-checking bench for the auto-negotiation register set
`timescale 1ns/1ps
module anr_ability_regs_tb;
  import anr_pkg::*;
  logic        i_clk;
  logic        i_nrst;
  logic        i_mdc;
  wire         i_mdio;
  logic        o_mdio;
  logic        o_mdio_oe;
  logic        i_remote_fault;
  logic        i_ack_tx;
  logic        i_lp_an_able;
  logic        i_page_rx;
  logic [15:0] i_lp_word;
  logic        i_par_det_fault;
  logic [15:0] o_adv_word;
  logic [15:0] o_ctrl_word;
  logic        m_oe;
  logic        m_dat;
  logic        seen_oe;
  logic [15:0] rd;
  int          errors;
  int          checks;

  // Management line has a pull-up when nobody drives it
  assign i_mdio = o_mdio_oe ? o_mdio : (m_oe ? m_dat : 1'b1);

  anr_ability_regs i_anr_ability_regs
  (
    .i_clk           (i_clk),
    .i_nrst          (i_nrst),
    .i_mdc           (i_mdc),
    .i_mdio          (i_mdio),
    .o_mdio          (o_mdio),
    .o_mdio_oe       (o_mdio_oe),
    .i_remote_fault  (i_remote_fault),
    .i_ack_tx        (i_ack_tx),
    .i_lp_an_able    (i_lp_an_able),
    .i_page_rx       (i_page_rx),
    .i_lp_word       (i_lp_word),
    .i_par_det_fault (i_par_det_fault),
    .o_adv_word      (o_adv_word),
    .o_ctrl_word     (o_ctrl_word)
  );

  anr_link_partner i_anr_link_partner
  (
    .i_clk     (i_clk),
    .o_page_rx (i_page_rx),
    .o_lp_word (i_lp_word)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic print_verdict;
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One management bit: clock high and low for two system cycles each;
  // s is the line level just before this rise
  task automatic mbit(input logic b, output logic s);
    @(negedge i_clk);
    s = i_mdio;
    i_mdc = 1'b1;
    m_dat = b;
    repeat (2) @(negedge i_clk);
    i_mdc = 1'b0;
    @(negedge i_clk);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rdat);
    logic [31:0] hdr;
    logic        s;
    hdr = {2'b01, op, phy, ra, 2'b10, wd};
    rdat = 16'h0000;
    m_oe = 1'b1;
    repeat (32) mbit(1'b1, s);
    for (int i = 31; i >= 0; i--)
    begin
      if (i == 17 && op == ANR_OP_RD)
        m_oe = 1'b0;
      if (i == 15)
        seen_oe = o_mdio_oe;
      mbit(hdr[i], s);
      if (i < 16)
        rdat[i] = s;
    end
    m_oe = 1'b1;
    repeat (2) @(negedge i_clk);
  endtask

  task automatic rchk(input logic [4:0] ra, input logic [15:0] exp);
    frame(ANR_OP_RD, ANR_PHY_ADDR, ra, 16'hFFFF, rd);
    check(rd, exp);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    frame(ANR_OP_WR, ANR_PHY_ADDR, ra, wd, rd);
  endtask

  initial
  begin
    #1_000_000;
    errors++;
    print_verdict();
  end

  initial
  begin
    errors = 0;
    checks = 0;
    i_nrst = 1'b0;
    i_mdc = 1'b0;
    m_oe = 1'b1;
    m_dat = 1'b1;
    seen_oe = 1'b0;
    i_remote_fault = 1'b0;
    i_ack_tx = 1'b0;
    i_lp_an_able = 1'b0;
    i_par_det_fault = 1'b0;
    repeat (5) @(negedge i_clk);
    i_nrst = 1'b1;
    check(o_adv_word, 16'h05E1);
    check(o_ctrl_word, 16'h0000);
    rchk(ANR_REG_ADV, 16'h05E1);
    check({15'h0000, seen_oe}, 16'h0001);
    check({15'h0000, o_mdio_oe}, 16'h0000);
    rchk(ANR_REG_CTRL, 16'h0000);
    rchk(ANR_REG_EXP, 16'h0004);
    rchk(ANR_REG_LP, 16'h0000);
    rchk(5'h07, 16'h0000);
    // Each ability bit alone, so a swapped pair of bits shows up
    for (int b = 5; b <= 8; b++)
    begin
      wr(ANR_REG_ADV, 16'h0001 << b);
      rchk(ANR_REG_ADV, 16'h0401 | (16'h0001 << b));
      check(o_adv_word, 16'h0401 | (16'h0001 << b));
    end
    wr(ANR_REG_ADV, 16'hFFFF);
    rchk(ANR_REG_ADV, 16'h85E1);
    i_remote_fault = 1'b1;
    i_ack_tx = 1'b1;
    repeat (2) @(negedge i_clk);
    check(o_adv_word, 16'hE5E1);
    rchk(ANR_REG_ADV, 16'hE5E1);
    i_remote_fault = 1'b0;
    i_ack_tx = 1'b0;
    wr(ANR_REG_ADV, 16'h0000);
    rchk(ANR_REG_ADV, 16'h0401);
    // Foreign or bit-reversed address, and a bad opcode, are refused
    frame(ANR_OP_WR, 5'h03, ANR_REG_ADV, 16'hFFFF, rd);
    frame(2'h3, ANR_PHY_ADDR, ANR_REG_ADV, 16'hFFFF, rd);
    rchk(ANR_REG_ADV, 16'h0401);
    frame(ANR_OP_RD, 5'h19, ANR_REG_ADV, 16'hFFFF, rd);
    check(rd, 16'hFFFF);
    check({15'h0000, seen_oe}, 16'h0000);
    i_lp_an_able = 1'b1;
    i_anr_link_partner.send_page(16'hA5E1);
    rchk(ANR_REG_LP, 16'hA5E1);
    rchk(ANR_REG_EXP, 16'h000F);
    rchk(ANR_REG_EXP, 16'h000D);
    i_anr_link_partner.send_page(16'h4001);
    rchk(ANR_REG_LP, 16'h4001);
    rchk(ANR_REG_EXP, 16'h0007);
    @(negedge i_clk);
    i_par_det_fault = 1'b1;
    @(negedge i_clk);
    i_par_det_fault = 1'b0;
    rchk(ANR_REG_EXP, 16'h0015);
    rchk(ANR_REG_EXP, 16'h0005);
    wr(ANR_REG_EXP, 16'hFFFF);
    wr(ANR_REG_LP, 16'h0000);
    rchk(ANR_REG_EXP, 16'h0005);
    rchk(ANR_REG_LP, 16'h4001);
    wr(ANR_REG_CTRL, 16'hFFFF);
    check(o_ctrl_word, 16'h7D80);
    rchk(ANR_REG_CTRL, 16'h7D80);
    i_lp_an_able = 1'b0;
    rchk(ANR_REG_EXP, 16'h0004);
    print_verdict();
  end
endmodule
